// File: hw/pirq_pkg.sv
// package of the prioritized interrupt request unit: register indices,
// reset values, field positions and the fixed per-source ranking.
// assumes a 32-bit apb register port in which each index takes one word.
package pirq_pkg;

  // apb geometry: byte address is four times the register index
  localparam int          ADDR_W = 14;
  localparam int          DATA_W = 32;
  localparam int          IDX_W  = 12;

  // register indices
  localparam logic [11:0] IDX_REQ0 = 12'hFC0; // request_pending_timers_adc
  localparam logic [11:0] IDX_ENH0 = 12'hFC1; // priority_enable_high, timers/adc
  localparam logic [11:0] IDX_ENL0 = 12'hFC2; // priority_enable_low, timers/adc
  localparam logic [11:0] IDX_REQ2 = 12'hFC6; // request_pending_port_c
  localparam logic [11:0] IDX_ENH2 = 12'hFC7; // priority_enable_high, port c
  localparam logic [11:0] IDX_ENL2 = 12'hFC8; // priority_enable_low, port c
  localparam logic [11:0] IDX_CTRL = 12'hFCF; // global enable and watchdog enable
  localparam logic [11:0] IDX_STAT = 12'hFD0; // sticky event status, read clears
  localparam logic [11:0] IDX_MASK = 12'hFD1; // event mask for bus_irq

  // reset values
  localparam logic [7:0]  REQ_RST  = 8'h00;
  localparam logic [7:0]  EN_RST   = 8'h00;
  localparam logic [7:0]  CTRL_RST = 8'h00;

  // control register fields
  localparam int          GIE_BIT    = 7;
  localparam int          WDT_EN_BIT = 0;

  // sources in fixed rank order, index 0 ranks highest
  localparam int          NUM_SRC  = 11;
  localparam int          NUM_TRAP = 4;
  localparam int          SRC_WDT  = 0;
  localparam int          SRC_POSC = 1;
  localparam int          SRC_WOSC = 2;
  localparam int          SRC_ILL  = 3;
  localparam int          SRC_T1   = 4;
  localparam int          SRC_T0   = 5;
  localparam int          SRC_ADC  = 6;
  localparam int          SRC_PC3  = 7;

  // where each maskable source sits in its request and enable registers
  localparam logic [10:0] SRC_IN_REQ2 = 11'h780;
  localparam logic [2:0]  SRC_BIT [0:10] = '{3'h0, 3'h0, 3'h0, 3'h0,
                                             3'h6, 3'h5, 3'h0,
                                             3'h3, 3'h2, 3'h1, 3'h0};
  localparam logic [1:0]  LVL_TOP  = 2'h3;
  localparam logic [1:0]  LVL_OFF  = 2'h0;

  typedef logic [3:0] pirq_vec_t;

endpackage

// File: hw/pirq_unit.sv
// prioritized interrupt request unit: pending latches, three-level
// priority with fixed in-level rank, vectored forward to the core.
// assumes one clock, single-cycle request pulses and an apb master.
//
// Contract
// - Three levels exist and any pending level 3 beats level 2, which beats level 1.
// - Among pending requests at one level the fixed per-source rank decides.
// - Watchdog (when enabled), both oscillator-fail traps and illegal instruction rank at level 3.
// - A request pulse sets its pending bit, which stays set until cleared.
// - Core acknowledgement clears the pending bit of the acknowledged request.
// - A software write of 0 to a pending bit clears that request.
// - With global enable set, the selected pending request is forwarded as a vectored interrupt.
// - With global enable clear nothing maskable is forwarded and reads return current pending bits.
// - First request register: bit 6 timer 1, bit 5 timer 0, bit 0 converter, 1 meaning pending.
// - Second request register bits 3 to 0 hold port c pins 3 to 0; bits 7 to 4 are written zero.
// - Two enable bits per source encode priority: 00 off, 01 level 1, 10 level 2, 11 level 3.
// - Global enable clears on write 0, acknowledgement, reset and traps; write 1 sets it.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps

module pirq_unit (
  // clock and reset
  input  wire  logic                          ref_clk,
  input  wire  logic                          nrst,
  // apb slave
  input  wire  logic                          psel,
  input  wire  logic                          penable,
  input  wire  logic                          pwrite,
  input  wire  logic [pirq_pkg::ADDR_W-1:0]   paddr,
  input  wire  logic [pirq_pkg::DATA_W-1:0]   pwdata,
  output logic       [pirq_pkg::DATA_W-1:0]   prdata,
  output logic                                pready,
  output logic                                pslverr,
  // request pulses from peripherals and trap logic
  input  wire  logic                          timer_one_pulse,
  input  wire  logic                          timer_zero_pulse,
  input  wire  logic                          converter_pulse,
  input  wire  logic [3:0]                    portc_pulse,
  input  wire  logic                          watchdog_pulse,
  input  wire  logic                          posc_fail_pulse,
  input  wire  logic                          wosc_fail_pulse,
  input  wire  logic                          illegal_op_pulse,
  // processor core side
  output logic                                core_irq,
  output pirq_pkg::pirq_vec_t                 core_vector,
  input  wire  logic                          core_ack,
  // summary interrupt of the bus event status
  output logic                                bus_irq
);
  import pirq_pkg::*;

  logic                 sync1_q;
  logic                 rst_n;
  logic [NUM_SRC-1:0]   src_set;
  logic [NUM_SRC-1:0]   pend_q;
  logic [NUM_SRC-1:0]   pend_d;
  logic [NUM_SRC-1:0]   wr_clr;
  logic [NUM_SRC-1:0]   ack_clr;
  logic [NUM_SRC-1:0]   elig;
  logic [1:0]           lvl [NUM_SRC];
  logic [7:0]           enh0_q;
  logic [7:0]           enl0_q;
  logic [7:0]           enh2_q;
  logic [7:0]           enl2_q;
  logic                 gie_q;
  logic                 wdt_en_q;
  logic [NUM_SRC-1:0]   stat_q;
  logic [NUM_SRC-1:0]   mask_q;
  logic                 sel_found;
  logic [1:0]           sel_lvl;
  pirq_vec_t            sel_idx;
  logic                 ack_take;
  logic [IDX_W-1:0]     idx;
  logic                 addr_hit;
  logic                 acc_end;
  logic                 wr_req0;
  logic                 wr_req2;
  logic                 rd_stat;
  logic [DATA_W-1:0]    rdata;
  logic [7:0]           req0_view;
  logic [7:0]           req2_view;
  logic [DATA_W-1:0]    prdata_q;
  logic                 pready_q;
  logic                 pslverr_q;
  logic                 core_irq_q;
  pirq_vec_t            core_vec_q;
  logic                 bus_irq_q;

  // reset release through two flip-flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      sync1_q <= 1'b1;
      rst_n   <= sync1_q;
    end
  end

  // source pulses in rank order; watchdog only counts when enabled
  assign src_set = {portc_pulse[0], portc_pulse[1], portc_pulse[2], portc_pulse[3],
                    converter_pulse, timer_zero_pulse, timer_one_pulse,
                    illegal_op_pulse, wosc_fail_pulse, posc_fail_pulse,
                    watchdog_pulse & wdt_en_q};

  // apb decode; a transfer ends on the second access cycle
  assign idx      = paddr[ADDR_W-1:2];
  assign addr_hit = (paddr[1:0] == 2'h0) &&
                    (idx == IDX_REQ0 || idx == IDX_ENH0 || idx == IDX_ENL0 ||
                     idx == IDX_REQ2 || idx == IDX_ENH2 || idx == IDX_ENL2 ||
                     idx == IDX_CTRL || idx == IDX_STAT || idx == IDX_MASK);
  assign acc_end  = psel && penable && pready_q;
  assign wr_req0  = acc_end && pwrite && addr_hit && idx == IDX_REQ0;
  assign wr_req2  = acc_end && pwrite && addr_hit && idx == IDX_REQ2;
  assign rd_stat  = acc_end && !pwrite && addr_hit && idx == IDX_STAT;

  // core acknowledges the vector it currently sees
  assign ack_take = core_ack && core_irq_q;

  // per-source pending bit, level and eligibility
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : gen_src
      if (g < NUM_TRAP) begin : gen_trap
        assign lvl[g]    = LVL_TOP;
        assign wr_clr[g] = 1'b0;
      end else begin : gen_mask
        // two enable bits give the level
        assign lvl[g]    = SRC_IN_REQ2[g] ? {enh2_q[SRC_BIT[g]], enl2_q[SRC_BIT[g]]}
                                          : {enh0_q[SRC_BIT[g]], enl0_q[SRC_BIT[g]]};
        // a zero written to the bit clears it
        assign wr_clr[g] = SRC_IN_REQ2[g] ? (wr_req2 && !pwdata[SRC_BIT[g]])
                                          : (wr_req0 && !pwdata[SRC_BIT[g]]);
      end
      assign ack_clr[g] = ack_take && (core_vec_q == pirq_vec_t'(g));
      // pulse wins over any clear in the same cycle
      assign pend_d[g]  = src_set[g] | (pend_q[g] & ~wr_clr[g] & ~ack_clr[g]);
      // maskable sources need global enable; traps do not
      assign elig[g]    = pend_q[g] && (lvl[g] != LVL_OFF) && (g < NUM_TRAP || gie_q);
    end
  endgenerate

  // pending register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // highest level wins, lower index wins a tie
  always_comb begin
    sel_found = 1'b0;
    sel_lvl   = LVL_OFF;
    sel_idx   = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (elig[i] && lvl[i] >= sel_lvl) begin
        sel_found = 1'b1;
        sel_lvl   = lvl[i];
        sel_idx   = pirq_vec_t'(i);
      end
    end
  end

  // forward to the core; drop one cycle after an acknowledge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_irq_q <= 1'b0;
      core_vec_q <= '0;
    end else begin
      core_irq_q <= sel_found && !ack_take;
      core_vec_q <= sel_idx;
    end
  end

  // enable registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enh0_q <= EN_RST;
      enl0_q <= EN_RST;
      enh2_q <= EN_RST;
      enl2_q <= EN_RST;
    end else if (acc_end && pwrite && addr_hit) begin
      if (idx == IDX_ENH0) enh0_q <= pwdata[7:0];
      if (idx == IDX_ENL0) enl0_q <= pwdata[7:0];
      if (idx == IDX_ENH2) enh2_q <= pwdata[7:0];
      if (idx == IDX_ENL2) enl2_q <= pwdata[7:0];
    end
  end

  // global enable: acknowledge and traps clear it ahead of a write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gie_q    <= CTRL_RST[GIE_BIT];
      wdt_en_q <= CTRL_RST[WDT_EN_BIT];
    end else begin
      if (ack_take || |src_set[NUM_TRAP-1:0]) begin
        gie_q <= 1'b0;
      end else if (acc_end && pwrite && addr_hit && idx == IDX_CTRL) begin
        gie_q <= pwdata[GIE_BIT];
      end
      if (acc_end && pwrite && addr_hit && idx == IDX_CTRL) begin
        wdt_en_q <= pwdata[WDT_EN_BIT];
      end
    end
  end

  // sticky event status and mask; a new event beats the read clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q    <= '0;
      mask_q    <= '0;
      bus_irq_q <= 1'b0;
    end else begin
      // a read clears only the bits it reported, so an event at the capture edge survives
      stat_q    <= (rd_stat ? (stat_q & ~prdata_q[NUM_SRC-1:0]) : stat_q) | src_set;
      bus_irq_q <= |(stat_q & mask_q);
      if (acc_end && pwrite && addr_hit && idx == IDX_MASK) begin
        mask_q <= pwdata[NUM_SRC-1:0];
      end
    end
  end

  // read views; reserved bits read zero
  assign req0_view = {1'b0, pend_q[SRC_T1], pend_q[SRC_T0], 4'h0, pend_q[SRC_ADC]};
  assign req2_view = {4'h0, pend_q[SRC_PC3 +: 4]};

  // read mux for the current address
  always_comb begin
    rdata = '0;
    case (idx)
      IDX_REQ0: rdata[7:0] = req0_view;
      IDX_REQ2: rdata[7:0] = {req2_view[7:4], req2_view[0], req2_view[1],
                              req2_view[2], req2_view[3]};
      IDX_ENH0: rdata[7:0] = enh0_q;
      IDX_ENL0: rdata[7:0] = enl0_q;
      IDX_ENH2: rdata[7:0] = enh2_q;
      IDX_ENL2: rdata[7:0] = enl2_q;
      IDX_CTRL: begin
        rdata[GIE_BIT]    = gie_q;
        rdata[WDT_EN_BIT] = wdt_en_q;
      end
      IDX_STAT: rdata[NUM_SRC-1:0] = stat_q;
      IDX_MASK: rdata[NUM_SRC-1:0] = mask_q;
      default:  rdata = '0;
    endcase
    if (!addr_hit) begin
      rdata = '0;
    end
  end

  // apb answer: one wait state, error on unmapped or unaligned address
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !addr_hit;
      if (psel && penable && !pready_q) begin
        prdata_q <= pwrite ? '0 : rdata;
      end
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign core_irq    = core_irq_q;
  assign core_vector = core_vec_q;
  assign bus_irq     = bus_irq_q;

  // pulse on timer 1 always shows as pending next cycle
  chk_pulse_sets_pend: assert property (@(posedge ref_clk) disable iff (!rst_n)
    timer_one_pulse |=> pend_q[SRC_T1])
    else $error("timer 1 pulse did not set its pending bit");

  // clearing write and pulse together keep the bit
  chk_set_beats_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_req0 && !pwdata[6] && timer_one_pulse) |=> pend_q[SRC_T1] ##1
      (pend_q[SRC_T1] || $past(ack_clr[SRC_T1]) || $past(wr_clr[SRC_T1])))
    else $error("pending bit lost on simultaneous pulse and clear");

  // zero write clears converter request
  chk_write_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_req0 && !pwdata[0] && !converter_pulse) |=> !pend_q[SRC_ADC])
    else $error("write of zero did not clear converter request");

  // acknowledge clears the acknowledged bit and drops global enable
  chk_ack_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ack_take && core_vec_q == pirq_vec_t'(SRC_T0) && !timer_zero_pulse)
      |=> !pend_q[SRC_T0] && !gie_q)
    else $error("acknowledge left pending bit or global enable set");

  // a trap pulse drops global enable
  chk_trap_gie: assert property (@(posedge ref_clk) disable iff (!rst_n)
    illegal_op_pulse |=> !gie_q)
    else $error("trap did not clear global enable");

  // a write of one sets global enable when no ack or trap clears it
  chk_gie_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (acc_end && pwrite && addr_hit && idx == IDX_CTRL && pwdata[GIE_BIT] && !ack_take &&
     !(|src_set[NUM_TRAP-1:0])) |=> gie_q)
    else $error("write of one did not set global enable");

  // maskable vectors only leave while global enable was set
  chk_gie_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (core_irq_q && core_vec_q >= pirq_vec_t'(NUM_TRAP)) |-> $past(gie_q))
    else $error("maskable request forwarded with global enable clear");

  // a pending trap always wins
  chk_trap_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (core_irq_q && $past(|pend_q[NUM_TRAP-1:0])) |-> core_vec_q < pirq_vec_t'(NUM_TRAP))
    else $error("trap pending but maskable vector presented");

  // timer 0 never wins over a higher-level or same-level timer 1
  chk_level_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (core_irq_q && core_vec_q == pirq_vec_t'(SRC_T0))
      |-> !($past(pend_q[SRC_T1]) && $past(lvl[SRC_T1]) > $past(lvl[SRC_T0])))
    else $error("lower level request beat a higher level");

  chk_rank_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (core_irq_q && core_vec_q == pirq_vec_t'(SRC_T0))
      |-> !($past(pend_q[SRC_T1]) && $past(lvl[SRC_T1]) == $past(lvl[SRC_T0])))
    else $error("lower ranked source beat a higher ranked one");

  // disabled source is never presented
  chk_disabled_src: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (core_irq_q && core_vec_q == pirq_vec_t'(SRC_ADC)) |-> $past(lvl[SRC_ADC]) != LVL_OFF)
    else $error("disabled converter request was forwarded");

  // read of first request register shows pending bits
  chk_req0_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (psel && penable && !pready_q && !pwrite && addr_hit && idx == IDX_REQ0)
      |=> prdata_q[6] == $past(pend_q[SRC_T1]) && prdata_q[0] == $past(pend_q[SRC_ADC]))
    else $error("first request register read mismatch");

  // read of port c register shows pin 3 in bit 3
  chk_req2_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (psel && penable && !pready_q && !pwrite && addr_hit && idx == IDX_REQ2)
      |=> prdata_q[3] == $past(pend_q[SRC_PC3]) && prdata_q[7:4] == 4'h0)
    else $error("port c request register read mismatch");

endmodule

// File: verification/pirq_core_model.sv
// core model: takes the vector the unit presents and acknowledges it
// assumes one clock and an ack that the unit samples only with core_irq high
`timescale 1ns/1ps

module pirq_core_model (
  // clock
  input  wire  logic                ref_clk,
  // link to the unit
  input  wire  logic                core_irq,
  input  wire  pirq_pkg::pirq_vec_t core_vector,
  output logic                      core_ack,
  // bench side
  input  wire  logic [3:0]          delay,
  output int                        ack_cnt,
  output pirq_pkg::pirq_vec_t       last_vec
);
  import pirq_pkg::*;

  int wait_q;

  // idle at time zero
  initial begin
    core_ack = 1'b0;
    ack_cnt  = 0;
    last_vec = '0;
    wait_q   = 0;
  end

  // wait delay cycles on a raised request, then ack for one cycle
  always @(posedge ref_clk) begin
    if (core_ack) begin
      core_ack <= 1'b0;
      ack_cnt  <= ack_cnt + 1;  // vector taken at the ack edge
      last_vec <= core_vector;
      wait_q   <= 0;
    end else if (core_irq && wait_q >= delay) begin
      core_ack <= 1'b1;
    end else if (core_irq) begin
      wait_q <= wait_q + 1;
    end
  end
endmodule

// File: verification/prioritized_interrupt_request_unit_bench.sv
// bench of the interrupt request unit: apb master, pulse sources, core model
// assumes one 100 MHz clock and the one-wait-state apb answer of the unit
`timescale 1ns/1ps

`define CHK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
  end \
end

module prioritized_interrupt_request_unit_bench;
  import pirq_pkg::*;

  logic              ref_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd, pm;
  logic              t1_p, t0_p, adc_p, wdt_p, posc_p, wosc_p, ill_p;
  logic [3:0]        pc_p, delay;
  logic              core_irq, core_ack, bus_irq, gie_m;
  pirq_vec_t         core_vector, last_vec;
  logic [10:0]       pend_m, stat_m;
  logic [1:0]        lvl [0:10];
  int                err_count, cmp_count, ack_cnt, seen;

  pirq_unit uut (
    .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_one_pulse(t1_p),
    .timer_zero_pulse(t0_p), .converter_pulse(adc_p), .portc_pulse(pc_p),
    .watchdog_pulse(wdt_p), .posc_fail_pulse(posc_p), .wosc_fail_pulse(wosc_p),
    .illegal_op_pulse(ill_p), .core_irq(core_irq), .core_vector(core_vector),
    .core_ack(core_ack), .bus_irq(bus_irq)
  );

  pirq_core_model core (
    .ref_clk(ref_clk), .core_irq(core_irq), .core_vector(core_vector),
    .core_ack(core_ack), .delay(delay), .ack_cnt(ack_cnt), .last_vec(last_vec)
  );

  // free running clock
  always #5 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one apb transfer; read data and error taken at the completing edge
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    int k;
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_count++;
      report_and_stop();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // sources in rank order, each high for exactly one clock
  task automatic pulse(input logic [10:0] m);
    @(posedge ref_clk);
    {adc_p, t0_p, t1_p, ill_p, wosc_p, posc_p, wdt_p} <= m[6:0];
    pc_p <= {m[7], m[8], m[9], m[10]};
    pend_m = pend_m | m;
    stat_m = stat_m | m;
    if (|m[3:0]) gie_m = 1'b0;
    @(posedge ref_clk);
    {adc_p, t0_p, t1_p, ill_p, wosc_p, posc_p, wdt_p, pc_p} <= '0;
  endtask

  // model: highest level wins, lowest source index breaks a tie
  function automatic int best();
    int b, bl, e;
    b  = -1;
    bl = 0;
    for (int i = 0; i < NUM_SRC; i++) begin
      e = (i < NUM_TRAP) ? 3 : ((gie_m === 1'b1) ? int'(lvl[i]) : 0);
      if (pend_m[i] === 1'b1 && e > bl) begin
        b  = i;
        bl = e;
      end
    end
    return b;
  endfunction

  // pending registers against the model, spare bits read zero
  task automatic chk_req();
    apb(1'b0, IDX_REQ0, 32'h0);
    `CHK(rd, {25'h0, pend_m[4], pend_m[5], 4'h0, pend_m[6]})
    apb(1'b0, IDX_REQ2, 32'h0);
    `CHK(rd, {28'h0, pend_m[7], pend_m[8], pend_m[9], pend_m[10]})
  endtask

  // random levels into the enable register pairs
  task automatic set_levels();
    for (int i = NUM_TRAP; i < NUM_SRC; i++) lvl[i] = 2'($urandom_range(3));
    apb(1'b1, IDX_ENH0, {25'h0, lvl[4][1], lvl[5][1], 4'h0, lvl[6][1]});
    apb(1'b1, IDX_ENL0, {25'h0, lvl[4][0], lvl[5][0], 4'h0, lvl[6][0]});
    apb(1'b1, IDX_ENH2, {28'h0, lvl[7][1], lvl[8][1], lvl[9][1], lvl[10][1]});
    apb(1'b1, IDX_ENL2, {28'h0, lvl[7][0], lvl[8][0], lvl[9][0], lvl[10][0]});
  endtask

  // serve every eligible request through the core, re-enabling after acks
  task automatic serve();
    int v, k;
    v = best();
    while (v >= 0) begin
      seen = ack_cnt;
      k = 0;
      while (ack_cnt == seen && k < 100) begin
        @(posedge ref_clk);
        k++;
      end
      if (k >= 100) begin
        err_count++;
        report_and_stop();
      end
      `CHK(last_vec, 4'(v))
      pend_m[v] = 1'b0;
      gie_m = 1'b0;
      if (best() < 0) begin
        repeat (3) @(posedge ref_clk);
        `CHK(core_irq, 1'b0) // ack dropped the global enable
        apb(1'b1, IDX_CTRL, 32'h81);
        gie_m = 1'b1;
      end
      v = best();
    end
  endtask

  // main sequence
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, delay} = '0;
    {adc_p, t0_p, t1_p, ill_p, wosc_p, posc_p, wdt_p, pc_p} = '0;
    {pend_m, stat_m, gie_m} = '0;
    err_count = 0;
    cmp_count = 0;
    pm = $urandom(32'hDA12);
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk_req();
    apb(1'b0, 12'h000, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    $display("test reset done");
    // polling with global enable off, every maskable source at level 3
    apb(1'b1, IDX_CTRL, 32'h01);
    apb(1'b1, IDX_ENH0, 32'h61);
    apb(1'b1, IDX_ENL0, 32'h61);
    apb(1'b1, IDX_ENH2, 32'h0F);
    apb(1'b1, IDX_ENL2, 32'h0F);
    pm = $urandom;
    pulse({pm[3:0], 7'h70});
    repeat (3) @(posedge ref_clk);
    `CHK(core_irq, 1'b0)
    chk_req();
    $display("test poll done");
    // clearing write with a new timer 1 pulse at the same edge
    fork
      apb(1'b1, IDX_REQ0, 32'h01); // zero bits clear, spare bits zero
      begin
        repeat (2) @(posedge ref_clk);
        pulse(11'h010);
      end
    join
    pend_m[5] = 1'b0;
    chk_req();
    apb(1'b1, IDX_REQ0, 32'h0); // direct clear, never read-modify-write
    apb(1'b1, IDX_REQ2, 32'h0);
    pend_m[10:4] = '0;
    $display("test clear done");
    // rounds of random levels and simultaneous requests
    for (int r = 0; r < 8; r++) begin
      delay = 4'($urandom_range(3));
      set_levels();
      apb(1'b1, IDX_CTRL, 32'h81);
      gie_m = 1'b1;
      pm = $urandom;
      pulse(pm[10:0]);
      serve();
      chk_req();
      apb(1'b1, IDX_REQ0, 32'h0);
      apb(1'b1, IDX_REQ2, 32'h0);
      pend_m[10:4] = '0;
    end
    $display("test priority done");
    // sticky status, mask and read clear
    apb(1'b1, IDX_MASK, 32'h010);
    apb(1'b0, IDX_STAT, 32'h0);
    `CHK(rd, {21'h0, stat_m})
    pulse(11'h020);
    repeat (3) @(posedge ref_clk);
    `CHK(bus_irq, 1'b0)
    pulse(11'h010);
    repeat (3) @(posedge ref_clk);
    `CHK(bus_irq, 1'b1)
    apb(1'b0, IDX_STAT, 32'h0);
    `CHK(rd, 32'h030)
    repeat (3) @(posedge ref_clk);
    `CHK(bus_irq, 1'b0)
    $display("test status done");
    report_and_stop();
  end
endmodule
